// >>> rtl/epg_pkg.sv
// package for the edge port interrupt and general-purpose pin block
package epg_pkg;
    localparam int NPINS = 8;
    // register indices; printed offsets are not word multiples, byte address = 4 * index
    localparam logic [23:0] IDX_PIN_MODE_SELECT  = 24'hC60000;
    localparam logic [23:0] IDX_PIN_DIRECTION    = 24'hC60002;
    localparam logic [23:0] IDX_INTERRUPT_ENABLE = 24'hC60003;
    localparam logic [23:0] IDX_OUTPUT_DATA      = 24'hC60004;
    localparam logic [23:0] IDX_PIN_STATE        = 24'hC60005;
    localparam logic [23:0] IDX_EDGE_FLAGS       = 24'hC60006;
    localparam logic [23:0] IDX_IRQ_STATUS       = 24'hC60008;
    localparam logic [23:0] IDX_IRQ_MASK         = 24'hC60009;
    localparam logic [25:0] ADDR_PIN_MODE_SELECT  = {IDX_PIN_MODE_SELECT, 2'b00};
    localparam logic [25:0] ADDR_PIN_DIRECTION    = {IDX_PIN_DIRECTION, 2'b00};
    localparam logic [25:0] ADDR_INTERRUPT_ENABLE = {IDX_INTERRUPT_ENABLE, 2'b00};
    localparam logic [25:0] ADDR_OUTPUT_DATA      = {IDX_OUTPUT_DATA, 2'b00};
    localparam logic [25:0] ADDR_PIN_STATE        = {IDX_PIN_STATE, 2'b00};
    localparam logic [25:0] ADDR_EDGE_FLAGS       = {IDX_EDGE_FLAGS, 2'b00};
    localparam logic [25:0] ADDR_IRQ_STATUS       = {IDX_IRQ_STATUS, 2'b00};
    localparam logic [25:0] ADDR_IRQ_MASK         = {IDX_IRQ_MASK, 2'b00};
    // reset values
    localparam logic [15:0] RST_PIN_MODE_SELECT  = 16'h0000;
    localparam logic [7:0]  RST_PIN_DIRECTION    = 8'h00;
    localparam logic [7:0]  RST_INTERRUPT_ENABLE = 8'h00;
    localparam logic [7:0]  RST_OUTPUT_DATA      = 8'hFF;
    localparam logic [7:0]  RST_EDGE_FLAGS       = 8'h00;
    localparam logic [7:0]  RST_IRQ_MASK         = 8'h00;
    // detection mode encodings of a two-bit pin_mode_field
    localparam logic [1:0] MODE_LEVEL_LOW = 2'b00;
    localparam logic [1:0] MODE_RISING    = 2'b01;
    localparam logic [1:0] MODE_FALLING   = 2'b10;
    localparam logic [1:0] MODE_BOTH      = 2'b11;
endpackage : epg_pkg

// >>> rtl/epg_pin_if.sv
// interface carrying pin samples and per-pin control into the detector
`timescale 1ns/1ns
`default_nettype none
interface epg_pin_if;
    logic [7:0]  pin_level;
    logic [7:0]  pin_prev;
    logic [15:0] pin_mode_select;
    logic [7:0]  edge_seen;
    modport ctl (output pin_level, output pin_prev, output pin_mode_select, input edge_seen);
    modport det (input pin_level, input pin_prev, input pin_mode_select, output edge_seen);
endinterface : epg_pin_if
`default_nettype wire

// >>> rtl/epg_edge_detect.sv
// per-pin edge detector selected by the two-bit mode field
`timescale 1ns/1ns
`default_nettype none
module epg_edge_detect (
    epg_pin_if.det pins
);
    // one detector per pin; level mode never reports an edge
    genvar g;
    generate
        for (g = 0; g < epg_pkg::NPINS; g++) begin : g_pin
            wire logic [1:0] mode = pins.pin_mode_select[2*g +: 2];
            wire logic       rise = pins.pin_level[g] & ~pins.pin_prev[g];
            wire logic       fall = ~pins.pin_level[g] & pins.pin_prev[g];
            assign pins.edge_seen[g] =
                ((mode == epg_pkg::MODE_RISING) & rise) |
                ((mode == epg_pkg::MODE_FALLING) & fall) |
                ((mode == epg_pkg::MODE_BOTH) & (rise | fall));
        end
    endgenerate
endmodule : epg_edge_detect
`default_nettype wire

// >>> rtl/epg_top.sv
// edge port: eight interrupt / general-purpose pins with register port
`timescale 1ns/1ns
`default_nettype none
// How it works
// - direction bit one drives pin as output; reset clears all direction bits.
// - direction and detection mode are separate registers, never touching each other.
// - enabled pin requests while its edge flag is set, even if set earlier.
// - enabled level-mode pin requests while synchronised level is low, unlatched.
// - clearing enable drops request at once; reset clears all enables.
// - output data stored, drives output pins, reads return stored value.
// - reset sets output data to all ones.
// - pin state read-only, shows synchronised levels two cycles late, writes ignored, no reset.
// - selected edge on an edge-mode pin sets its flag.
// - flag stays set until a one is written to it; zero ignored.
// - level mode pins never set their flag.
// - reset clears all edge flags.
// - mode field 00 level low, 01 rise, 10 fall, 11 both; reset clears.
// - pin values pass a two-stage synchroniser before reads and detection.
// - edge detection works regardless of pin direction.
module epg_top (
    input  wire logic        mclk_i,
    input  wire logic        reset_i,
    input  wire logic [25:0] addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,
    input  wire logic [7:0]  ext_irq_pin_i,
    output logic      [7:0]  ext_irq_pin_o,
    output logic      [7:0]  ext_irq_pin_oe_n_o,
    output logic      [7:0]  pin_irq_o,
    output logic             irq_o
);
    logic [15:0] pin_mode_select;
    logic [7:0]  pin_direction;
    logic [7:0]  interrupt_enable;
    logic [7:0]  output_data;
    logic [7:0]  edge_flags;
    logic [7:0]  irq_status;
    logic [7:0]  irq_mask;
    logic [7:0]  sync_a;
    logic [7:0]  sync_b;
    logic [7:0]  sync_prev;
    logic [31:0] next_rdata;

    epg_pin_if pins ();
    epg_edge_detect u_detect (
        .pins (pins.det)
    );

    // detector sees only the second stage and its delayed copy
    assign pins.pin_level       = sync_b;
    assign pins.pin_prev        = sync_prev;
    assign pins.pin_mode_select = pin_mode_select;

    // address decode
    wire logic sel_mode   = addr_i == epg_pkg::ADDR_PIN_MODE_SELECT;
    wire logic sel_dir    = addr_i == epg_pkg::ADDR_PIN_DIRECTION;
    wire logic sel_ien    = addr_i == epg_pkg::ADDR_INTERRUPT_ENABLE;
    wire logic sel_odata  = addr_i == epg_pkg::ADDR_OUTPUT_DATA;
    wire logic sel_pstate = addr_i == epg_pkg::ADDR_PIN_STATE;
    wire logic sel_flags  = addr_i == epg_pkg::ADDR_EDGE_FLAGS;
    wire logic sel_status = addr_i == epg_pkg::ADDR_IRQ_STATUS;
    wire logic sel_mask   = addr_i == epg_pkg::ADDR_IRQ_MASK;

    // level condition per pin: mode 00 and synchronised low
    wire logic [7:0] level_low;
    genvar g;
    generate
        for (g = 0; g < epg_pkg::NPINS; g++) begin : g_lvl
            assign level_low[g] = (pin_mode_select[2*g +: 2] == epg_pkg::MODE_LEVEL_LOW)
                                  & ~sync_b[g];
        end
    endgenerate

    // flags: edge sets win over a same-cycle write-one clear
    wire logic [7:0] flag_clr   = (wr_i && sel_flags) ? wdata_i[7:0] : 8'h00;
    wire logic [7:0] next_flags = (edge_flags & ~flag_clr) | pins.edge_seen;
    wire logic [7:0] next_req   = interrupt_enable & (edge_flags | level_low);
    wire logic [7:0] stat_clr   = (wr_i && sel_status) ? wdata_i[7:0] : 8'h00;
    wire logic [7:0] next_stat  = (irq_status & ~stat_clr) | pins.edge_seen;

    // enable written this cycle gates the request with its new value
    wire logic [7:0] next_ien = (wr_i && sel_ien) ? wdata_i[7:0] : interrupt_enable;
    wire logic [7:0] next_pin_irq = next_ien & (next_flags | level_low);

    // read mux; unmapped addresses and upper bits read zero
    // pin state shows the synchronised copy, so a read lags the pin by two cycles
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (sel_mode) next_rdata[15:0] = pin_mode_select;
        if (sel_dir) next_rdata[7:0] = pin_direction;
        if (sel_ien) next_rdata[7:0] = interrupt_enable;
        if (sel_odata) next_rdata[7:0] = output_data;
        if (sel_pstate) next_rdata[7:0] = sync_b;
        if (sel_flags) next_rdata[7:0] = edge_flags;
        if (sel_status) next_rdata[7:0] = irq_status;
        if (sel_mask) next_rdata[7:0] = irq_mask;
    end

    // synchroniser: first stage feeds only the second; no reset on pin state
    // two stages cost two cycles of latency on every edge and level request,
    // traded for freedom from metastable samples reaching the flags
    always_ff @(posedge mclk_i) begin
        sync_a    <= ext_irq_pin_i;
        sync_b    <= sync_a;
        sync_prev <= sync_b;
    end

    // software registers
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            pin_mode_select  <= epg_pkg::RST_PIN_MODE_SELECT;
            pin_direction    <= epg_pkg::RST_PIN_DIRECTION;
            interrupt_enable <= epg_pkg::RST_INTERRUPT_ENABLE;
            output_data      <= epg_pkg::RST_OUTPUT_DATA;
            irq_mask         <= epg_pkg::RST_IRQ_MASK;
        end else if (wr_i) begin
            // each register has its own select, so mode and direction stay apart
            if (sel_mode) pin_mode_select <= wdata_i[15:0];
            if (sel_dir) pin_direction <= wdata_i[7:0];
            if (sel_ien) interrupt_enable <= wdata_i[7:0];
            if (sel_odata) output_data <= wdata_i[7:0];
            if (sel_mask) irq_mask <= wdata_i[7:0];
        end
    end

    // sticky flags and status
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            edge_flags <= epg_pkg::RST_EDGE_FLAGS;
            irq_status <= epg_pkg::RST_EDGE_FLAGS;
        end else begin
            edge_flags <= next_flags;
            irq_status <= next_stat;
        end
    end

    // registered outputs
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            rdata_o            <= 32'h0000_0000;
            ext_irq_pin_o      <= epg_pkg::RST_OUTPUT_DATA;
            ext_irq_pin_oe_n_o <= 8'hFF;
            pin_irq_o          <= 8'h00;
            irq_o              <= 1'b0;
        end else begin
            rdata_o            <= rd_i ? next_rdata : 32'h0000_0000;
            ext_irq_pin_o      <= (wr_i && sel_odata) ? wdata_i[7:0] : output_data;
            ext_irq_pin_oe_n_o <= (wr_i && sel_dir) ? ~wdata_i[7:0] : ~pin_direction;
            pin_irq_o          <= next_pin_irq;
            irq_o              <= |(next_stat & irq_mask);
        end
    end

    // assertions
    flag_sticky_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        (edge_flags != 8'h00 && !(wr_i && sel_flags)) |=> ((edge_flags & $past(edge_flags)) == $past(edge_flags)))
        else $error("edge flag dropped without a clear");
    flag_clear_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        (wr_i && sel_flags && pins.edge_seen == 8'h00) |=> ((edge_flags & $past(wdata_i[7:0])) == 8'h00))
        else $error("write one did not clear flag");
    level_noflag_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        (pin_mode_select == 16'h0000 && edge_flags == 8'h00) |=> edge_flags == 8'h00)
        else $error("level mode pin set a flag");
    req_drop_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        (wr_i && sel_ien) |=> ((pin_irq_o & ~$past(wdata_i[7:0])) == 8'h00))
        else $error("request stayed after enable cleared");
    req_flag_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        ((interrupt_enable & edge_flags) != 8'h00 && !wr_i)
        |=> ((pin_irq_o & $past(interrupt_enable & edge_flags)) == $past(interrupt_enable & edge_flags)))
        else $error("enabled flag raised no request");
    rise_set_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        (pin_mode_select[5:4] == epg_pkg::MODE_RISING && sync_b[2] && !sync_prev[2]) |=> edge_flags[2])
        else $error("rising edge not flagged");
    out_drive_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        (wr_i && sel_odata) |=> ext_irq_pin_o == $past(wdata_i[7:0]))
        else $error("output data not driven");
    pstate_read_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        (rd_i && sel_pstate) |=> rdata_o[7:0] == $past(sync_b))
        else $error("pin state read wrong");
    oe_dir_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        (wr_i && sel_dir) |=> ext_irq_pin_oe_n_o == ~$past(wdata_i[7:0]))
        else $error("direction not applied");

    // reset values, checked on the edge after reset is seen high
    rst_dir_a: assert property (@(posedge mclk_i)
        reset_i
        |=> (pin_direction == epg_pkg::RST_PIN_DIRECTION && ext_irq_pin_oe_n_o == 8'hFF))
        else $error("direction not cleared by reset");
    // enables and requests both drop in reset
    rst_ien_a: assert property (@(posedge mclk_i)
        reset_i
        |=> (interrupt_enable == epg_pkg::RST_INTERRUPT_ENABLE && pin_irq_o == 8'h00))
        else $error("enable not cleared by reset");
    // output data comes up all ones, on the register and the pins
    rst_odata_a: assert property (@(posedge mclk_i)
        reset_i
        |=> (output_data == epg_pkg::RST_OUTPUT_DATA && ext_irq_pin_o == epg_pkg::RST_OUTPUT_DATA))
        else $error("output data not set by reset");
    // no edge is remembered across a reset
    rst_flags_a: assert property (@(posedge mclk_i)
        reset_i
        |=> (edge_flags == epg_pkg::RST_EDGE_FLAGS))
        else $error("flags not cleared by reset");
    // every pin starts in level mode
    rst_mode_a: assert property (@(posedge mclk_i)
        reset_i
        |=> (pin_mode_select == epg_pkg::RST_PIN_MODE_SELECT))
        else $error("mode not cleared by reset");

    // a zero written to a flag bit must leave that bit alone
    flag_zero_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        (wr_i && sel_flags)
        |=> ((edge_flags & $past(edge_flags & ~wdata_i[7:0])) == $past(edge_flags & ~wdata_i[7:0])))
        else $error("zero write cleared a flag");
    // an edge in the same cycle as a clear still leaves its flag set
    edge_wins_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        (pins.edge_seen != 8'h00)
        |=> ((edge_flags & $past(pins.edge_seen)) == $past(pins.edge_seen)))
        else $error("detected edge lost");
    // a flag only rises where the detector saw an edge
    flag_source_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        1'b1
        |=> ((edge_flags & ~$past(edge_flags | pins.edge_seen)) == 8'h00))
        else $error("flag set with no edge");
    // pin 2 in level mode keeps a clear flag clear through any transition
    level_keep_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        (pin_mode_select[5:4] == epg_pkg::MODE_LEVEL_LOW && !edge_flags[2])
        |=> !edge_flags[2])
        else $error("level mode pin changed its flag");
    // falling mode catches a high to low step
    fall_set_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        (pin_mode_select[5:4] == epg_pkg::MODE_FALLING && !sync_b[2] && sync_prev[2])
        |=> edge_flags[2])
        else $error("falling edge not flagged");
    // both-edges mode catches either step
    both_set_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        (pin_mode_select[5:4] == epg_pkg::MODE_BOTH && (sync_b[2] != sync_prev[2]))
        |=> edge_flags[2])
        else $error("edge not flagged in both mode");
    // rising mode must ignore falls, so a clear flag stays clear without a rise
    rise_only_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        (pin_mode_select[5:4] == epg_pkg::MODE_RISING && !edge_flags[2] && !(sync_b[2] && !sync_prev[2]))
        |=> !edge_flags[2])
        else $error("rising mode flagged a fall");

    // a low level on an enabled level-mode pin requests on the next edge
    level_req_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        (interrupt_enable[2] && !(wr_i && sel_ien) && pin_mode_select[5:4] == epg_pkg::MODE_LEVEL_LOW && !sync_b[2])
        |=> pin_irq_o[2])
        else $error("low level raised no request");
    // level requests are not latched: a high pin with no flag requests nothing
    level_free_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        (pin_mode_select[5:4] == epg_pkg::MODE_LEVEL_LOW && sync_b[2] && !edge_flags[2])
        |=> !pin_irq_o[2])
        else $error("level request latched");
    // with every enable off and none written, no pin may request
    req_gate_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        (interrupt_enable == 8'h00 && !(wr_i && sel_ien))
        |=> (pin_irq_o == 8'h00))
        else $error("request without enable");

    // direction and mode writes never disturb each other
    dir_indep_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        (wr_i && sel_dir)
        |=> (pin_mode_select == $past(pin_mode_select)))
        else $error("direction write changed mode");
    mode_indep_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        (wr_i && sel_mode)
        |=> (pin_direction == $past(pin_direction)))
        else $error("mode write changed direction");
    // a write to the pin state slot lands nowhere
    pstate_ro_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        (wr_i && sel_pstate)
        |=> (output_data == $past(output_data) && pin_direction == $past(pin_direction)))
        else $error("pin state write had an effect");
    // reads of output data return the stored bits, not the pins
    odata_read_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        (rd_i && sel_odata)
        |=> (rdata_o[7:0] == $past(output_data)))
        else $error("output data read wrong");
    // without a write the pins keep showing the stored data
    out_hold_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        !(wr_i && sel_odata)
        |=> (ext_irq_pin_o == $past(output_data)))
        else $error("pin drive drifted");
    // without a write the enables keep following the direction bits
    dir_hold_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        !(wr_i && sel_dir)
        |=> (ext_irq_pin_oe_n_o == ~$past(pin_direction)))
        else $error("enable drifted from direction");
    // the pins reach the detector exactly two edges late
    sync_path_a: assert property (@(posedge mclk_i) disable iff (reset_i)
        1'b1
        |=> ##1 (sync_b == $past(ext_irq_pin_i, 2)))
        else $error("synchroniser depth wrong");
endmodule : epg_top
`default_nettype wire

// >>> tb/epg_pin_model.sv
// model of the external interrupt sources that share the eight pins
`timescale 1ns/1ns
`default_nettype none
module epg_pin_model (
    input  wire logic [7:0] src_i,
    input  wire logic [7:0] drv_i,
    input  wire logic [7:0] oe_n_i,
    output logic      [7:0] pin_o
);
    // a source drives only the pins left as inputs, so it never fights the block
    assign pin_o = (src_i & oe_n_i) | (drv_i & ~oe_n_i);
endmodule : epg_pin_model
`default_nettype wire

// >>> tb/epg_top_tb.sv
// self-checking testbench of the edge port block
`timescale 1ns/1ns
`default_nettype none
module epg_top_tb;
    logic        mclk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic [25:0] addr = 26'h0;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        rd_q = 1'b0;
    logic [31:0] rdata;
    logic [7:0]  src = 8'h00;
    logic [7:0]  pin;
    logic [7:0]  drv;
    logic [7:0]  oe_n;
    logic [7:0]  pin_irq;
    logic        irq;
    logic [31:0] exp_q[$];
    logic [31:0] r;
    int          seed = 32'h299d;
    int          bad_count = 0;
    int          cmp_count = 0;
    epg_top dut_u (.mclk_i(mclk_i), .reset_i(reset_i), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .ext_irq_pin_i(pin), .ext_irq_pin_o(drv),
        .ext_irq_pin_oe_n_o(oe_n), .pin_irq_o(pin_irq), .irq_o(irq));
    epg_pin_model pm_u (.src_i(src), .drv_i(drv), .oe_n_i(oe_n), .pin_o(pin));
    initial begin
        forever #20 mclk_i = ~mclk_i;
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    // one-cycle strobes with an idle edge after, so no strobe is set twice at once
    task automatic wr_reg(input logic [25:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk_i);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [25:0] a, input logic [31:0] e);
        @(posedge mclk_i);
        addr <= a;
        rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge mclk_i);
        rd <= 1'b0;
    endtask : rd_reg
    // outputs launched by a write settle one edge later; look mid-cycle after that
    task automatic settle;
        repeat (2) @(negedge mclk_i);
    endtask : settle
    task automatic pin_set(input logic [7:0] v);
        @(posedge mclk_i);
        src <= v;
        repeat (5) @(posedge mclk_i);
    endtask : pin_set
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish
    // read data stand for the one cycle after the strobe; look mid-cycle
    always @(posedge mclk_i) rd_q <= rd;
    always @(negedge mclk_i) begin
        if (rd_q === 1'b1)
            check("rdata", rdata, exp_q.pop_front());
    end
    initial begin
        #(40 * 4000);
        bad_count++;
        tally_and_finish();
    end
    initial begin
        repeat (4) @(posedge mclk_i);
        reset_i <= 1'b0;
        rd_reg(epg_pkg::ADDR_PIN_DIRECTION, 32'(epg_pkg::RST_PIN_DIRECTION));
        rd_reg(epg_pkg::ADDR_INTERRUPT_ENABLE, 32'(epg_pkg::RST_INTERRUPT_ENABLE));
        rd_reg(epg_pkg::ADDR_OUTPUT_DATA, 32'(epg_pkg::RST_OUTPUT_DATA));
        rd_reg(epg_pkg::ADDR_EDGE_FLAGS, 32'(epg_pkg::RST_EDGE_FLAGS));
        rd_reg(epg_pkg::ADDR_PIN_MODE_SELECT, 32'(epg_pkg::RST_PIN_MODE_SELECT));
        rd_reg(26'h0000010, 32'h0);
        check("oe_n", 32'(oe_n), 32'hFF);
        // each mode on pin 2, a rise then a fall, flags cleared between
        for (int m = 0; m < 4; m++) begin
            wr_reg(epg_pkg::ADDR_PIN_MODE_SELECT, 32'(m) << 4);
            wr_reg(epg_pkg::ADDR_EDGE_FLAGS, 32'hFF);
            pin_set(8'h04);
            rd_reg(epg_pkg::ADDR_EDGE_FLAGS, m[0] ? 32'h4 : 32'h0);
            wr_reg(epg_pkg::ADDR_EDGE_FLAGS, 32'hFF);
            pin_set(8'h00);
            rd_reg(epg_pkg::ADDR_EDGE_FLAGS, m[1] ? 32'h4 : 32'h0);
        end
        // a flag already set requests once enabled, and stays until a one is written
        wr_reg(epg_pkg::ADDR_EDGE_FLAGS, 32'h0);
        rd_reg(epg_pkg::ADDR_EDGE_FLAGS, 32'h4);
        check("irq", 32'(irq), 32'h0);
        wr_reg(epg_pkg::ADDR_IRQ_MASK, 32'h4);
        settle();
        check("irq", 32'(irq), 32'h1);
        wr_reg(epg_pkg::ADDR_IRQ_STATUS, 32'hFF);
        settle();
        check("irq", 32'(irq), 32'h0);
        wr_reg(epg_pkg::ADDR_INTERRUPT_ENABLE, 32'h4);
        settle();
        check("pin_irq", 32'(pin_irq), 32'h4);
        wr_reg(epg_pkg::ADDR_INTERRUPT_ENABLE, 32'h0);
        settle();
        check("pin_irq", 32'(pin_irq), 32'h0);
        wr_reg(epg_pkg::ADDR_EDGE_FLAGS, 32'h4);
        rd_reg(epg_pkg::ADDR_EDGE_FLAGS, 32'h0);
        // level mode follows the low pin without latching
        wr_reg(epg_pkg::ADDR_PIN_MODE_SELECT, 32'h0);
        wr_reg(epg_pkg::ADDR_INTERRUPT_ENABLE, 32'h4);
        repeat (2) @(posedge mclk_i);
        check("pin_irq", 32'(pin_irq), 32'h4);
        pin_set(8'h04);
        check("pin_irq", 32'(pin_irq), 32'h0);
        pin_set(8'h00);
        wr_reg(epg_pkg::ADDR_INTERRUPT_ENABLE, 32'h0);
        // pin 2 driven as output raises its own rising edge
        r = 32'($random(seed)) & 32'hFF | 32'h4;
        wr_reg(epg_pkg::ADDR_PIN_MODE_SELECT, 32'h10);
        wr_reg(epg_pkg::ADDR_OUTPUT_DATA, 32'h0);
        wr_reg(epg_pkg::ADDR_PIN_DIRECTION, 32'h4);
        wr_reg(epg_pkg::ADDR_EDGE_FLAGS, 32'hFF);
        wr_reg(epg_pkg::ADDR_OUTPUT_DATA, r);
        settle();
        check("oe_n", 32'(oe_n), 32'hFB);
        check("drive", 32'(drv), r);
        repeat (5) @(posedge mclk_i);
        rd_reg(epg_pkg::ADDR_EDGE_FLAGS, 32'h4);
        rd_reg(epg_pkg::ADDR_OUTPUT_DATA, r);
        rd_reg(epg_pkg::ADDR_PIN_MODE_SELECT, 32'h10);
        wr_reg(epg_pkg::ADDR_PIN_STATE, 32'hFF);
        rd_reg(epg_pkg::ADDR_PIN_STATE, 32'h4);
        r = 32'($random(seed)) & 32'hFF;
        wr_reg(epg_pkg::ADDR_PIN_DIRECTION, r);
        rd_reg(epg_pkg::ADDR_PIN_DIRECTION, r);
        repeat (3) @(posedge mclk_i);
        tally_and_finish();
    end
endmodule : epg_top_tb
`default_nettype wire
